// ===== core/ddb_mem_ctl.sv
// Memory controller end: row management, bursts and refresh scheduling
// Function
// - Activate opens addressed row in selected bank
// - Precharge bank before activating another row
// - Precharge closes banks; reopen after precharge time
// - Concurrent auto precharge must not disturb transfers
// - Activate an idle bank before read or write
// - Precharge of idle bank restarts precharge time
// - Address bit 12 picks chop four or eight
// - Address bit 12 never part of column
// - Fixed-eight or on-the-fly mode allows eight
// - Data setup/hold fault spoils only addressed location
// - Strobe timing fault spoils only addressed location
// - Other timing faults need full reinitialisation
// - Refresh command code starts one refresh
// - One refresh per average refresh interval
// - All banks idle precharge time before refresh
// - Refresh rows from internal counter, address ignored
// - Only no-operations during refresh cycle time
// - At most eight refreshes postponed
// - At most eight refreshes pulled in
// - Issue postponed refreshes before self refresh
`timescale 1ns/1ps
`default_nettype none
module ddb_mem_ctl (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic RST,
	// Link to the memory device
	ddb_link_if.ctl LINK,
	// Request port
	input wire logic REQ_VALID,
	output logic REQ_READY,
	input wire logic REQ_WRITE,
	input wire logic [ddb_pkg::BANK_W-1:0] REQ_BANK,
	input wire logic [ddb_pkg::ROW_W-1:0] REQ_ROW,
	input wire logic [ddb_pkg::COL_W-1:0] REQ_COL,
	input wire logic REQ_CHOP,
	input wire logic [ddb_pkg::BEATS_MAX*ddb_pkg::DQ_W-1:0] REQ_WDATA,
	// Read answer
	output logic RD_VALID,
	output logic [ddb_pkg::BEATS_MAX*ddb_pkg::DQ_W-1:0] RD_DATA,
	// Refresh debt
	output logic [ddb_pkg::OWED_W-1:0] REFRESH_OWED
);
	import ddb_pkg::*;
	ddb_ctl_state_t s;
	ddb_ctl_state_t next_s;
	logic ref_force;
	logic owed_inc;
	logic owed_dec;

	// Debt at the postpone limit blocks new requests until a refresh is paid
	assign ref_force = $signed(s.owed) >= POSTPONE_MAX;
	assign REQ_READY = s.ck && s.st == S_IDLE && !ref_force;

	always_comb begin
		next_s = s;
		owed_inc = 1'b0;
		owed_dec = 1'b0;
		next_s.ck = ~s.ck;
		next_s.rd_valid = 1'b0;
		// Read data crosses from the link clock through two flops, the strobe through three
		next_s.dq_s1 = LINK.dq;
		next_s.dq_s2 = s.dq_s1;
		next_s.dqs_s1 = LINK.dqs;
		next_s.dqs_s2 = s.dqs_s1;
		next_s.dqs_s3 = s.dqs_s2;
		// Each strobe change marks one read beat
		// No timeout: a device that never answers leaves this end waiting
		if (s.st == S_RDWAIT && s.dqs_s2 != s.dqs_s3) begin
			next_s.rdata[s.beat] = s.dq_s2;
			next_s.beat = s.beat + 3'h1;
			if (s.beat == s.last) begin
				next_s.rd_valid = 1'b1;
				next_s.st = S_IDLE;
			end
		end
		// Link outputs change as the link clock falls, so the device sees them settled
		if (s.ck) begin
			next_s.cmd = CMD_NOP;
			next_s.dq_oe = 1'b0;
			if (s.refi == REFI_LAST) begin
				next_s.refi = '0;
				owed_inc = $signed(s.owed) < POSTPONE_MAX;
			end else begin
				next_s.refi = s.refi + CNT_W'(1);
			end
			case (s.st)
				S_MRS: begin
					next_s.cmd = CMD_MRS;
					next_s.ba = '0;
					next_s.addr = ROW_W'(BL_OTF);
					next_s.st = S_IDLE;
				end
				// Each wait ends one link cycle late, trading speed for margin
				S_WAIT: begin
					if (s.wait_cnt == '0) begin
						next_s.st = s.after;
					end else begin
						next_s.wait_cnt = s.wait_cnt - CNT_W'(1);
					end
				end
				S_IDLE: begin
					// No self refresh here, so debt is never carried into it
					if (ref_force || (!REQ_VALID && $signed(s.owed) > PULLIN_MIN)) begin
						if (s.open != '0) begin
							next_s.cmd = CMD_PRE;
							next_s.addr = '0;
							next_s.addr[ADDR_AP_BIT] = 1'b1;
							next_s.open = '0;
							next_s.wait_cnt = PRE_LOAD;
							next_s.after = S_REF;
							next_s.st = S_WAIT;
						end else begin
							next_s.st = S_REF;
						end
					end else if (REQ_VALID) begin
						next_s.wr = REQ_WRITE;
						next_s.bank = REQ_BANK;
						next_s.rrow = REQ_ROW;
						next_s.col = REQ_COL;
						next_s.chop = REQ_CHOP;
						next_s.wdata = REQ_WDATA;
						if (s.open[REQ_BANK] && s.row[REQ_BANK] == REQ_ROW) begin
							next_s.st = S_COL;
						end else if (s.open[REQ_BANK]) begin
							next_s.cmd = CMD_PRE;
							next_s.ba = REQ_BANK;
							next_s.addr = '0;
							next_s.open[REQ_BANK] = 1'b0;
							next_s.wait_cnt = PRE_LOAD;
							next_s.after = S_ACT;
							next_s.st = S_WAIT;
						end else begin
							next_s.st = S_ACT;
						end
					end
				end
				S_ACT: begin
					next_s.cmd = CMD_ACT;
					next_s.ba = s.bank;
					next_s.addr = s.rrow;
					next_s.open[s.bank] = 1'b1;
					next_s.row[s.bank] = s.rrow;
					next_s.st = S_COL;
				end
				S_COL: begin
					next_s.cmd = s.wr ? CMD_WR : CMD_RD;
					next_s.ba = s.bank;
					next_s.addr = ROW_W'(s.col);
					// Auto precharge is never used, so no bank overlaps a precharge
					next_s.addr[ADDR_AP_BIT] = 1'b0;
					next_s.addr[ADDR_BC_BIT] = ~s.chop;
					next_s.beat = '0;
					next_s.last = s.chop ? LAST_CHOP : LAST_FULL;
					next_s.st = s.wr ? S_WDATA : S_RDWAIT;
				end
				S_WDATA: begin
					next_s.dq = s.wdata[s.beat];
					next_s.dq_oe = 1'b1;
					next_s.dqs = ~s.beat[0];
					next_s.beat = s.beat + 3'h1;
					if (s.beat == s.last) begin
						next_s.st = S_WEND;
					end
				end
				S_WEND: begin
					next_s.st = S_IDLE;
				end
				S_REF: begin
					next_s.cmd = CMD_REF;
					owed_dec = 1'b1;
					next_s.wait_cnt = RFC_LOAD;
					next_s.after = S_IDLE;
					next_s.st = S_WAIT;
				end
				default: ;
			endcase
		end
		if (owed_inc && !owed_dec) begin
			next_s.owed = s.owed + OWED_ONE;
		end else if (owed_dec && !owed_inc) begin
			next_s.owed = s.owed - OWED_ONE;
		end
	end

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign LINK.ck = s.ck;
	assign {LINK.cs_n, LINK.ras_n, LINK.cas_n, LINK.we_n} = s.cmd;
	assign LINK.ba = s.ba;
	assign LINK.addr = s.addr;
	assign LINK.ctl_dq_o = s.dq;
	assign LINK.ctl_dq_oe = s.dq_oe;
	assign LINK.ctl_dqs_o = s.dqs;
	assign LINK.ctl_dqs_oe = s.dq_oe;
	assign RD_VALID = s.rd_valid;
	assign RD_DATA = s.rdata;
	assign REFRESH_OWED = s.owed;
endmodule
`default_nettype wire

// ===== core/ddb_sdram_dev.sv
// Memory device end: banks, bursts, write strobe checks and refresh
`timescale 1ns/1ps
`default_nettype none
module ddb_sdram_dev (
	// Reset
	input wire logic RST,
	// Link, clocked by the link clock
	ddb_link_if.dev LINK,
	// Device state
	output logic [ddb_pkg::BANKS-1:0] BANK_OPEN,
	output logic [ddb_pkg::ROW_W-1:0] REFRESH_ROW,
	output logic [ddb_pkg::MR_BL_W-1:0] BURST_MODE,
	output logic WR_FAULT,
	output logic CMD_FAULT
);
	import ddb_pkg::*;
	ddb_dev_state_t s;
	ddb_dev_state_t next_s;
	logic [3:0] cmd;
	logic [BANK_W-1:0] ba;
	logic [LOC_W-1:0] loc;
	logic pre_busy;
	logic full;

	assign cmd = {LINK.cs_n, LINK.ras_n, LINK.cas_n, LINK.we_n};
	assign ba = LINK.ba;
	assign loc = {s.bank, LOC_COL_W'(s.col + s.beat)};

	always_comb begin
		next_s = s;
		pre_busy = 1'b0;
		full = (s.mr_bl == BL_FIXED8) || (s.mr_bl == BL_OTF && LINK.addr[ADDR_BC_BIT]);
		next_s.dq_oe = 1'b0;
		for (int b = 0; b < BANKS; b++) begin
			if (s.pre[b] != '0) begin
				next_s.pre[b] = s.pre[b] - CNT_W'(1);
				pre_busy = 1'b1;
			end
		end
		// A bad strobe only raises the write fault; the byte is still stored and the burst still ends on time
		if (s.op != OP_IDLE) begin
			if (s.op == OP_WR) begin
				next_s.mem[loc] = LINK.dq;
				if (LINK.dqs != ~s.beat[0]) begin
					next_s.wr_fault = 1'b1;
				end
			end else begin
				next_s.dq = s.mem[loc];
				next_s.dq_oe = 1'b1;
				next_s.dqs = ~s.beat[0];
			end
			next_s.beat = s.beat + 3'h1;
			if (s.beat == s.last) begin
				next_s.op = OP_IDLE;
				if (s.ap) begin
					next_s.open[s.bank] = 1'b0;
					next_s.pre[s.bank] = PRE_LOAD;
				end
			end
		end
		if (s.rfc != '0) begin
			next_s.rfc = s.rfc - CNT_W'(1);
		end else begin
			case (cmd)
				CMD_ACT: begin
					if (!s.open[ba] && s.pre[ba] == '0) begin
						next_s.open[ba] = 1'b1;
						next_s.row[ba] = LINK.addr;
					end else begin
						next_s.cmd_fault = 1'b1;
					end
				end
				CMD_PRE: begin
					for (int b = 0; b < BANKS; b++) begin
						if (LINK.addr[ADDR_AP_BIT] || BANK_W'(b) == ba) begin
							next_s.open[b] = 1'b0;
							next_s.pre[b] = PRE_LOAD;
						end
					end
				end
				CMD_RD, CMD_WR: begin
					if (s.open[ba] && s.op == OP_IDLE) begin
						next_s.op = (cmd == CMD_RD) ? OP_RD : OP_WR;
						next_s.beat = '0;
						next_s.last = full ? LAST_FULL : LAST_CHOP;
						next_s.bank = ba;
						next_s.col = LINK.addr[LOC_COL_W-1:0];
						next_s.ap = LINK.addr[ADDR_AP_BIT];
					end else begin
						next_s.cmd_fault = 1'b1;
					end
				end
				CMD_REF: begin
					if (s.open == '0 && !pre_busy && s.op == OP_IDLE) begin
						next_s.rfc = RFC_LOAD;
						next_s.ref_row = s.ref_row + ROW_W'(1);
					end else begin
						next_s.cmd_fault = 1'b1;
					end
				end
				CMD_MRS: begin
					if (ba == '0) begin
						next_s.mr_bl = LINK.addr[MR_BL_W-1:0];
					end
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge LINK.ck or posedge RST) begin
		if (RST) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign LINK.dev_dq_o = s.dq;
	assign LINK.dev_dq_oe = s.dq_oe;
	assign LINK.dev_dqs_o = s.dqs;
	assign LINK.dev_dqs_oe = s.dq_oe;
	assign BANK_OPEN = s.open;
	assign REFRESH_ROW = s.ref_row;
	assign BURST_MODE = s.mr_bl;
	assign WR_FAULT = s.wr_fault;
	assign CMD_FAULT = s.cmd_fault;
endmodule
`default_nettype wire

// ===== inc/ddb_link_if.sv
// Command, address and data link between controller and memory device
`timescale 1ns/1ps
`default_nettype none
interface ddb_link_if;
	import ddb_pkg::*;
	logic ck;
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic [BANK_W-1:0] ba;
	logic [ROW_W-1:0] addr;
	logic [DQ_W-1:0] ctl_dq_o;
	logic ctl_dq_oe;
	logic ctl_dqs_o;
	logic ctl_dqs_oe;
	logic [DQ_W-1:0] dev_dq_o;
	logic dev_dq_oe;
	logic dev_dqs_o;
	logic dev_dqs_oe;
	logic [DQ_W-1:0] dq;
	logic dqs;
	// Wire level: the enabled driver wins, an undriven wire reads low
	assign dq = dev_dq_oe ? dev_dq_o : (ctl_dq_oe ? ctl_dq_o : '0);
	assign dqs = dev_dqs_oe ? dev_dqs_o : (ctl_dqs_oe ? ctl_dqs_o : 1'b0);
	modport ctl (
		output ck, cs_n, ras_n, cas_n, we_n, ba, addr,
		output ctl_dq_o, ctl_dq_oe, ctl_dqs_o, ctl_dqs_oe,
		input dq, dqs
	);
	modport dev (
		input ck, cs_n, ras_n, cas_n, we_n, ba, addr, dq, dqs,
		output dev_dq_o, dev_dq_oe, dev_dqs_o, dev_dqs_oe
	);
endinterface
`default_nettype wire

// ===== inc/ddb_pkg.sv
// Shared constants and types for the DDR3 bank, burst and refresh link
`default_nettype none
package ddb_pkg;
	localparam int BANK_W = 3;
	localparam int ROW_W = 14;
	localparam int COL_W = 10;
	localparam int DQ_W = 8;
	localparam int BANKS = 8;
	localparam int BEATS_MAX = 8;
	localparam int LOC_COL_W = 3;
	localparam int LOC_W = BANK_W + LOC_COL_W;
	localparam int LOCS = 1 << LOC_W;
	localparam int CNT_W = 8;
	localparam int OWED_W = 5;
	localparam int MR_BL_W = 2;
	// The link clock is REF_CLK divided by two
	localparam int REF_PERIOD_PS = 40000;
	localparam int LINK_DIV = 2;
	localparam int LINK_PERIOD_PS = REF_PERIOD_PS * LINK_DIV;
	localparam int PRECHARGE_TIME_PS = 13750;
	localparam int REFRESH_CYCLE_TIME_PS = 110000;
	localparam int AVERAGE_REFRESH_INTERVAL_NS = 7800;
	localparam int PRE_CYC = (PRECHARGE_TIME_PS + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
	localparam int RFC_CYC = (REFRESH_CYCLE_TIME_PS + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
	localparam int REFI_CYC = AVERAGE_REFRESH_INTERVAL_NS * 1000 / LINK_PERIOD_PS;
	localparam logic [CNT_W-1:0] PRE_LOAD = CNT_W'(PRE_CYC - 1);
	localparam logic [CNT_W-1:0] RFC_LOAD = CNT_W'(RFC_CYC - 1);
	localparam logic [CNT_W-1:0] REFI_LAST = CNT_W'(REFI_CYC - 1);
	// Command codes as {cs_n, ras_n, cas_n, we_n}
	localparam logic [3:0] CMD_MRS = 4'h0;
	localparam logic [3:0] CMD_REF = 4'h1;
	localparam logic [3:0] CMD_PRE = 4'h2;
	localparam logic [3:0] CMD_ACT = 4'h3;
	localparam logic [3:0] CMD_WR = 4'h4;
	localparam logic [3:0] CMD_RD = 4'h5;
	localparam logic [3:0] CMD_NOP = 4'h7;
	localparam int ADDR_AP_BIT = 10;
	localparam int ADDR_BC_BIT = 12;
	localparam logic [MR_BL_W-1:0] BL_FIXED8 = 2'h0;
	localparam logic [MR_BL_W-1:0] BL_OTF = 2'h1;
	localparam logic [2:0] LAST_CHOP = 3'h3;
	localparam logic [2:0] LAST_FULL = 3'h7;
	localparam logic signed [OWED_W-1:0] POSTPONE_MAX = 5'sh08;
	localparam logic signed [OWED_W-1:0] PULLIN_MIN = 5'sh18;
	localparam logic signed [OWED_W-1:0] OWED_ONE = 5'sh01;

	typedef enum logic [1:0] {OP_IDLE, OP_WR, OP_RD} ddb_op_t;
	typedef enum logic [3:0] {
		S_MRS, S_IDLE, S_WAIT, S_ACT, S_COL, S_WDATA, S_WEND, S_RDWAIT, S_REF
	} ddb_ctl_st_t;

	typedef struct packed {
		logic [BANKS-1:0] open;
		logic [BANKS-1:0][ROW_W-1:0] row;
		logic [BANKS-1:0][CNT_W-1:0] pre;
		logic [MR_BL_W-1:0] mr_bl;
		logic [ROW_W-1:0] ref_row;
		logic [CNT_W-1:0] rfc;
		ddb_op_t op;
		logic [2:0] beat;
		logic [2:0] last;
		logic [BANK_W-1:0] bank;
		logic [LOC_COL_W-1:0] col;
		logic ap;
		logic [LOCS-1:0][DQ_W-1:0] mem;
		logic [DQ_W-1:0] dq;
		logic dq_oe;
		logic dqs;
		logic wr_fault;
		logic cmd_fault;
	} ddb_dev_state_t;

	typedef struct packed {
		logic ck;
		ddb_ctl_st_t st;
		ddb_ctl_st_t after;
		logic [CNT_W-1:0] wait_cnt;
		logic [CNT_W-1:0] refi;
		logic [OWED_W-1:0] owed;
		logic [BANKS-1:0] open;
		logic [BANKS-1:0][ROW_W-1:0] row;
		logic wr;
		logic [BANK_W-1:0] bank;
		logic [ROW_W-1:0] rrow;
		logic [COL_W-1:0] col;
		logic chop;
		logic [BEATS_MAX-1:0][DQ_W-1:0] wdata;
		logic [2:0] beat;
		logic [2:0] last;
		logic [3:0] cmd;
		logic [BANK_W-1:0] ba;
		logic [ROW_W-1:0] addr;
		logic [DQ_W-1:0] dq;
		logic dq_oe;
		logic dqs;
		logic [DQ_W-1:0] dq_s1;
		logic [DQ_W-1:0] dq_s2;
		logic dqs_s1;
		logic dqs_s2;
		logic dqs_s3;
		logic [BEATS_MAX-1:0][DQ_W-1:0] rdata;
		logic rd_valid;
	} ddb_ctl_state_t;
endpackage
`default_nettype wire

// ===== verification/ddb_link_asserts.sv
// Link protocol assertions between the controller and the memory device
`timescale 1ns/1ps
`default_nettype none
module ddb_link_asserts (
	// Link clock and reset
	input wire logic ck,
	input wire logic RST,
	// Command and address
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [ddb_pkg::ROW_W-1:0] addr,
	// Data drivers
	input wire logic ctl_dq_oe,
	input wire logic ctl_dqs_o,
	input wire logic dev_dq_oe,
	input wire logic dev_dqs_o
);
	import ddb_pkg::*;
	logic [3:0] cmd;
	assign cmd = {cs_n, ras_n, cas_n, we_n};
	default clocking cb @(posedge ck); endclocking
	default disable iff (RST);
	// Driver held for the whole burst, then released so the other end may drive
	sequence s_four(oe);
		oe [*4] ##1 !oe;
	endsequence
	sequence s_eight(oe);
		oe [*8] ##1 !oe;
	endsequence
	sequence s_strobe(s);
		s ##1 !s ##1 s ##1 !s;
	endsequence
	a_ref_then_quiet: assert property (cmd == CMD_REF |=> (cmd == CMD_NOP) [*2])
		else $error("command inside refresh cycle time");
	a_ref_banks_idle: assert property (cmd == CMD_REF |-> $past(cmd) != CMD_PRE
		&& $past(cmd) != CMD_ACT) else $error("refresh too soon after bank command");
	a_act_after_pre: assert property (cmd == CMD_ACT |-> $past(cmd) != CMD_PRE)
		else $error("activate inside precharge time");
	a_chop_read: assert property (cmd == CMD_RD && !addr[ADDR_BC_BIT] |-> ##2 s_four(dev_dq_oe))
		else $error("chopped read length wrong");
	a_full_read: assert property (cmd == CMD_RD && addr[ADDR_BC_BIT] |-> ##2 s_eight(dev_dq_oe))
		else $error("full read length wrong");
	a_chop_write: assert property (cmd == CMD_WR && !addr[ADDR_BC_BIT] |=> s_four(ctl_dq_oe))
		else $error("chopped write length wrong");
	a_full_write: assert property (cmd == CMD_WR && addr[ADDR_BC_BIT] |=> s_eight(ctl_dq_oe))
		else $error("full write length wrong");
	a_write_strobe: assert property ($rose(ctl_dq_oe) |-> s_strobe(ctl_dqs_o))
		else $error("write strobe pattern wrong");
	a_read_strobe: assert property ($rose(dev_dq_oe) |-> s_strobe(dev_dqs_o))
		else $error("read strobe pattern wrong");
	a_one_driver: assert property (!(ctl_dq_oe && dev_dq_oe))
		else $error("both ends drive data");
endmodule
`default_nettype wire

// ===== verification/ddr3_bank_burst_refresh_bench.sv
// Bench joining controller and memory device over the link
`timescale 1ns/1ps
`default_nettype none
module ddr3_bank_burst_refresh_bench;
	import ddb_pkg::*;
	logic ref_clk = 1'b0;
	logic rst = 1'b0;
	logic req_valid = 1'b0;
	logic req_ready;
	logic req_write = 1'b0;
	logic [BANK_W-1:0] req_bank = '0;
	logic [ROW_W-1:0] req_row = '0;
	logic [COL_W-1:0] req_col = '0;
	logic req_chop = 1'b0;
	logic [63:0] req_wdata = '0;
	logic rd_valid;
	logic [63:0] rd_data;
	logic [OWED_W-1:0] refresh_owed;
	logic [BANKS-1:0] bank_open;
	logic [ROW_W-1:0] refresh_row;
	logic [MR_BL_W-1:0] burst_mode;
	logic wr_fault;
	logic cmd_fault;
	// Storage is picked by bank and low column bits only
	logic [DQ_W-1:0] mem [BANKS][8];
	int n_mismatch = 0;
	int tests_run = 0;

	ddb_link_if link ();
	ddb_mem_ctl ddb_mem_ctl_i (.REF_CLK(ref_clk), .RST(rst), .LINK(link.ctl),
		.REQ_VALID(req_valid), .REQ_READY(req_ready), .REQ_WRITE(req_write),
		.REQ_BANK(req_bank), .REQ_ROW(req_row), .REQ_COL(req_col), .REQ_CHOP(req_chop),
		.REQ_WDATA(req_wdata), .RD_VALID(rd_valid), .RD_DATA(rd_data),
		.REFRESH_OWED(refresh_owed));
	ddb_sdram_dev ddb_sdram_dev_i (.RST(rst), .LINK(link.dev), .BANK_OPEN(bank_open),
		.REFRESH_ROW(refresh_row), .BURST_MODE(burst_mode), .WR_FAULT(wr_fault),
		.CMD_FAULT(cmd_fault));
	ddb_link_asserts ddb_link_asserts_i (.ck(link.ck), .RST(rst), .cs_n(link.cs_n),
		.ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n), .addr(link.addr),
		.ctl_dq_oe(link.ctl_dq_oe), .ctl_dqs_o(link.ctl_dqs_o),
		.dev_dq_oe(link.dev_dq_oe), .dev_dqs_o(link.dev_dqs_o));

	always #20 ref_clk = ~ref_clk;

	task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic report_and_stop();
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Entered at a falling edge; leaves one idle edge so valid never toggles twice at once
	task automatic req(input logic w, input logic [BANK_W-1:0] b, input logic [ROW_W-1:0] r,
			input logic [COL_W-1:0] c, input logic ch, input logic [63:0] d);
		int n;
		n = 0;
		req_write = w;
		req_bank = b;
		req_row = r;
		req_col = c;
		req_chop = ch;
		req_wdata = d;
		req_valid = 1'b1;
		while (req_ready !== 1'b1 && n < 999) begin
			@(negedge ref_clk);
			n++;
		end
		check("accept", 64'h1, 64'(n < 999));
		@(negedge ref_clk);
		req_valid = 1'b0;
		@(negedge ref_clk);
	endtask

	task automatic wr(input logic [BANK_W-1:0] b, input logic [ROW_W-1:0] r,
			input logic [COL_W-1:0] c, input logic ch, input logic [63:0] d);
		req(1'b1, b, r, c, ch, d);
		for (int k = 0; k < (ch ? 4 : 8); k++) begin
			mem[b][3'(c[2:0] + k)] = d[8*k +: 8];
		end
	endtask

	// Chopped reads only refresh the low four beats, so only those are compared
	task automatic rd(input logic [BANK_W-1:0] b, input logic [ROW_W-1:0] r,
			input logic [COL_W-1:0] c, input logic ch);
		logic [63:0] e;
		logic [63:0] m;
		int n;
		n = 0;
		m = ch ? 64'h0000_0000_FFFF_FFFF : 64'hFFFF_FFFF_FFFF_FFFF;
		for (int k = 0; k < 8; k++) begin
			e[8*k +: 8] = mem[b][3'(c[2:0] + k)];
		end
		req(1'b0, b, r, c, ch, 64'h0);
		while (rd_valid !== 1'b1 && n < 999) begin
			@(negedge ref_clk);
			n++;
		end
		check("read answer", 64'h1, 64'(n < 999));
		check("read data", e & m, rd_data & m);
	endtask

	initial begin
		#400000;
		n_mismatch++;
		report_and_stop();
	end

	initial begin
		logic [63:0] d;
		// A real rising edge, so the device end resets before its clock ever runs
		#1;
		rst = 1'b1;
		repeat (20) @(posedge ref_clk);
		@(negedge ref_clk);
		rst = 1'b0;
		repeat (150) @(negedge ref_clk);
		check("burst mode", 64'(BL_OTF), 64'(burst_mode));
		check("refresh debt", {59'h0, PULLIN_MIN}, 64'(refresh_owed));
		check("refresh row", 64'h8, 64'(refresh_row));
		check("banks idle", 64'h0, 64'(bank_open));
		for (int b = 0; b < BANKS; b++) begin
			d = 64'h0706050403020100 + 64'h1010101010101010 * b;
			wr(3'(b), 14'h3F00 | 14'(b), 10'h000, 1'b0, d);
		end
		for (int b = 0; b < BANKS; b++) begin
			rd(3'(b), 14'h3F00 | 14'(b), 10'h000, 1'b0);
		end
		wr(3'h3, 14'h2AAA, 10'h006, 1'b1, 64'hFFFF_FFFF_A1B2_C3D4);
		rd(3'h3, 14'h2AAA, 10'h000, 1'b0);
		rd(3'h3, 14'h2AAA, 10'h005, 1'b1);
		rd(3'h5, 14'h0001, 10'h3F9, 1'b0);
		wr(3'h5, 14'h0001, 10'h3FB, 1'b1, 64'h0000_0000_5A6B_7C8D);
		rd(3'h5, 14'h3F05, 10'h003, 1'b1);
		check("write fault", 64'h0, 64'(wr_fault));
		check("command fault", 64'h0, 64'(cmd_fault));
		report_and_stop();
	end
endmodule
`default_nettype wire
